/* File: design/stop_mode_power_control.v */
// Purpose: stop-mode entry and power-state control
// Assumes: 50 MHz SYS_CLK; stop strobe and debug commands are same-clock
// Notes: power and clock outputs are power-state levels: 1 on, 0 standby/off per port
`timescale 1ns/1ps
`default_nettype none
`include "stop_ctrl_consts.vh"

// Functional notes
// - background mode entry from run only with debug entry enabled
// - debug enabled stop keeps debug logic clock running
// - debug enabled stop keeps regulator in full regulation
// - deep stop request with debug enabled becomes light stop
// - in stop reject commands; status memory commands return stop error
// - background command in light stop wakes into background mode if enabled
// - in background mode every command is accepted
// - debug stop: light stop, clock generator and regulator active
// - low voltage raises interrupt or reset as configured
// - low voltage detect and low voltage stop enable both set in stop keeps regulator active
// - deep stop request with low voltage stop detect becomes light
// - low voltage stop: light stop, clock generator off, regulator active
// - any stop gates peripheral clocks even with debug clock on
// - deep stop turns off cpu, flash, ports, converter, clocks, serial, timers
// - light stop puts cpu, memories, ports, serial, timers in standby
// - light stop converter runs only with async clock and detector enabled
// - light stop oscillator runs with debug enabled, or with oscillator stop enable set and no low voltage stop
// - periodic wake runs in stop only with nonzero rate select
// - mode select one picks deep stop, zero picks light stop
// - stop with stop enable clear forces illegal opcode reset
module stop_mode_power_control (
    // clock and reset
    input wire SYS_CLK,
    input wire RST,
    // cpu side, same clock
    input wire STOP_EXEC,
    input wire STOP_INSTRUCTION_ENABLE,
    input wire DEEP_STOP_SELECT,
    // configuration, same clock
    input wire DEBUG_ENTRY_ENABLE,
    input wire LOWVOLT_DETECT_ENABLE,
    input wire LOWVOLT_STOP_ENABLE,
    input wire LOWVOLT_RESET_SELECT,
    input wire OSCILLATOR_STOP_ENABLE,
    input wire CONV_ASYNC_CLK_ENABLE,
    input wire [2:0] PERIODIC_WAKE_RATE_SELECT,
    // wake sources and detector, asynchronous pins
    input wire WAKE_PIN,
    input wire PERIODIC_WAKE_EVENT,
    input wire LOWVOLT_BELOW,
    // background debug command, same clock
    input wire CMD_VALID,
    input wire [1:0] CMD_CLASS,
    input wire DEBUG_GO,
    // command answer
    output wire CMD_ANS_VALID,
    output wire [1:0] CMD_ANS_CODE,
    output wire CMD_MEM_ACCESS,
    // state
    output reg STOP_LIGHT,
    output reg STOP_DEEP,
    output reg BACKGROUND_DEBUG_MODE,
    output reg ILLEGAL_OPCODE_RESET,
    output reg LOWVOLT_INTERRUPT,
    output reg LOWVOLT_RESET,
    // power and clock controls
    output reg DEBUG_CLK_EN,
    output reg PERIPH_CLK_EN,
    output reg REGULATOR_FULL,
    output reg CPU_ON,
    output reg CPU_POWERED,
    output reg FLASH_POWERED,
    output reg PORT_REGS_POWERED,
    output reg SERIAL_POWERED,
    output reg TIMER_POWERED,
    output reg PIN_HOLD,
    output reg CONV_RUN,
    output reg CONV_POWERED,
    output reg CLOCK_GEN_RUN,
    output reg CLOCK_GEN_POWERED,
    output reg PERIODIC_WAKE_RUN
);
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [3:0] illop_cnt_q;
    reg lv_below_q;
    reg [2:0] rate_q;
    wire wake_pin_s;
    wire rti_s;
    wire lv_s;
    wire wake_req;
    wire lv_stop;

    // picks the stop state from the overrides
    function [3:0] pick_stop;
        input deep_sel;
        input dbg_en;
        input lvs;
        begin
            if (deep_sel == `DEEP_SEL_VALUE && !dbg_en && !lvs) begin
                pick_stop = `ST_DEEP;
            end else begin
                pick_stop = `ST_LIGHT;
            end
        end
    endfunction

    // ************************************************************
    // input synchronisers and command filter
    // ************************************************************
    sync2 #(
        .WIDTH(3)
    ) u_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .din({WAKE_PIN, PERIODIC_WAKE_EVENT, LOWVOLT_BELOW}),
        .dout({wake_pin_s, rti_s, lv_s})
    );

    bkgnd_cmd_filter u_filter (
        .clk(SYS_CLK),
        .rst(RST),
        .in_stop(state_q[1] | state_q[2]),
        .in_bkgnd(state_q[3]),
        .debug_entry_enable(DEBUG_ENTRY_ENABLE),
        .cmd_valid(CMD_VALID),
        .cmd_class(CMD_CLASS),
        .ans_valid_q(CMD_ANS_VALID),
        .ans_code_q(CMD_ANS_CODE),
        .mem_access_q(CMD_MEM_ACCESS),
        .wake_req_q(wake_req)
    );

    assign lv_stop = LOWVOLT_DETECT_ENABLE & LOWVOLT_STOP_ENABLE;

    // ************************************************************
    // state sequencer
    // ************************************************************
    // next state from stop, wake and debug events
    always @* begin
        state_d = state_q;
        case (state_q)
            `ST_RUN: begin
                if (wake_req) begin
                    state_d = `ST_BKGND;
                end else if (STOP_EXEC && STOP_INSTRUCTION_ENABLE) begin
                    state_d = pick_stop(DEEP_STOP_SELECT, DEBUG_ENTRY_ENABLE, lv_stop);
                end
            end
            `ST_LIGHT: begin
                if (wake_req) begin
                    state_d = `ST_BKGND;
                end else if (wake_pin_s || (rti_s && rate_q != `RATE_OFF)) begin
                    state_d = `ST_RUN;
                end
            end
            `ST_DEEP: begin
                if (wake_pin_s || (rti_s && rate_q != `RATE_OFF)) begin
                    state_d = `ST_RUN;
                end
            end
            `ST_BKGND: begin
                if (DEBUG_GO) begin
                    state_d = `ST_RUN;
                end
            end
            default: state_d = `STATE_RESET;
        endcase
    end

    // state, captured rate and illegal opcode pulse
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_q <= `STATE_RESET;
            rate_q <= `RATE_OFF;
            illop_cnt_q <= 4'h0;
            lv_below_q <= 1'b0;
        end else begin
            state_q <= state_d;
            lv_below_q <= lv_s;
            if (state_q == `ST_RUN) begin
                rate_q <= PERIODIC_WAKE_RATE_SELECT;
            end
            if (state_q == `ST_RUN && STOP_EXEC && !STOP_INSTRUCTION_ENABLE) begin
                illop_cnt_q <= `ILLOP_CYCLES;
            end else if (illop_cnt_q != 4'h0) begin
                illop_cnt_q <= illop_cnt_q - 4'h1;
            end
        end
    end

    // ************************************************************
    // registered power and clock controls
    // ************************************************************
    // decode the next state into domain controls
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            STOP_LIGHT <= 1'b0;
            STOP_DEEP <= 1'b0;
            BACKGROUND_DEBUG_MODE <= 1'b0;
            ILLEGAL_OPCODE_RESET <= 1'b0;
            LOWVOLT_INTERRUPT <= 1'b0;
            LOWVOLT_RESET <= 1'b0;
            DEBUG_CLK_EN <= 1'b1;
            PERIPH_CLK_EN <= 1'b1;
            REGULATOR_FULL <= 1'b1;
            CPU_ON <= 1'b1;
            CPU_POWERED <= 1'b1;
            FLASH_POWERED <= 1'b1;
            PORT_REGS_POWERED <= 1'b1;
            SERIAL_POWERED <= 1'b1;
            TIMER_POWERED <= 1'b1;
            PIN_HOLD <= 1'b0;
            CONV_RUN <= 1'b1;
            CONV_POWERED <= 1'b1;
            CLOCK_GEN_RUN <= 1'b1;
            CLOCK_GEN_POWERED <= 1'b1;
            PERIODIC_WAKE_RUN <= 1'b0;
        end else begin
            STOP_LIGHT <= (state_d == `ST_LIGHT);
            STOP_DEEP <= (state_d == `ST_DEEP);
            BACKGROUND_DEBUG_MODE <= (state_d == `ST_BKGND);
            ILLEGAL_OPCODE_RESET <= (state_q == `ST_RUN && STOP_EXEC
                && !STOP_INSTRUCTION_ENABLE) || (illop_cnt_q > 4'h1);
            // detector event, one pulse per falling crossing
            LOWVOLT_INTERRUPT <= LOWVOLT_DETECT_ENABLE && lv_s && !lv_below_q
                && !LOWVOLT_RESET_SELECT;
            LOWVOLT_RESET <= LOWVOLT_DETECT_ENABLE && lv_s && !lv_below_q
                && LOWVOLT_RESET_SELECT;
            case (state_d)
                `ST_LIGHT: begin
                    DEBUG_CLK_EN <= DEBUG_ENTRY_ENABLE;
                    PERIPH_CLK_EN <= 1'b0;
                    REGULATOR_FULL <= DEBUG_ENTRY_ENABLE | lv_stop;
                    CPU_ON <= 1'b0;
                    CPU_POWERED <= 1'b1;
                    FLASH_POWERED <= 1'b1;
                    PORT_REGS_POWERED <= 1'b1;
                    SERIAL_POWERED <= 1'b1;
                    TIMER_POWERED <= 1'b1;
                    PIN_HOLD <= 1'b1;
                    CONV_RUN <= CONV_ASYNC_CLK_ENABLE & LOWVOLT_DETECT_ENABLE;
                    CONV_POWERED <= 1'b1;
                    // debug stop keeps generator active; otherwise per enable, off in low voltage stop
                    CLOCK_GEN_RUN <= DEBUG_ENTRY_ENABLE
                        | (OSCILLATOR_STOP_ENABLE & !lv_stop);
                    CLOCK_GEN_POWERED <= 1'b1;
                    PERIODIC_WAKE_RUN <= (rate_q != `RATE_OFF);
                end
                `ST_DEEP: begin
                    DEBUG_CLK_EN <= 1'b0;
                    PERIPH_CLK_EN <= 1'b0;
                    REGULATOR_FULL <= 1'b0;
                    CPU_ON <= 1'b0;
                    CPU_POWERED <= 1'b0;
                    FLASH_POWERED <= 1'b0;
                    PORT_REGS_POWERED <= 1'b0;
                    SERIAL_POWERED <= 1'b0;
                    TIMER_POWERED <= 1'b0;
                    PIN_HOLD <= 1'b1;
                    CONV_RUN <= 1'b0;
                    CONV_POWERED <= 1'b0;
                    CLOCK_GEN_RUN <= 1'b0;
                    CLOCK_GEN_POWERED <= 1'b0;
                    PERIODIC_WAKE_RUN <= (rate_q != `RATE_OFF);
                end
                default: begin
                    DEBUG_CLK_EN <= 1'b1;
                    PERIPH_CLK_EN <= 1'b1;
                    REGULATOR_FULL <= 1'b1;
                    CPU_ON <= (state_d == `ST_RUN);
                    CPU_POWERED <= 1'b1;
                    FLASH_POWERED <= 1'b1;
                    PORT_REGS_POWERED <= 1'b1;
                    SERIAL_POWERED <= 1'b1;
                    TIMER_POWERED <= 1'b1;
                    PIN_HOLD <= 1'b0;
                    CONV_RUN <= 1'b1;
                    CONV_POWERED <= 1'b1;
                    CLOCK_GEN_RUN <= 1'b1;
                    CLOCK_GEN_POWERED <= 1'b1;
                    PERIODIC_WAKE_RUN <= (PERIODIC_WAKE_RATE_SELECT != `RATE_OFF);
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: design/stop_ctrl_consts.vh */
// Purpose: shared constants for the stop-mode power controller
// Assumes: included by bare name from design files
// Notes: states are one-hot, command classes are small codes
`ifndef STOP_CTRL_CONSTS_VH
`define STOP_CTRL_CONSTS_VH

// one-hot states of the stop sequencer
`define ST_RUN 4'h1
`define ST_LIGHT 4'h2
`define ST_DEEP 4'h4
`define ST_BKGND 4'h8

// background command classes
`define CMD_NONINTRUSIVE 2'h0
`define CMD_MEM_STATUS 2'h1
`define CMD_BACKGROUND 2'h2
`define CMD_ACTIVE_ONLY 2'h3

// command answer codes
`define ANS_OK 2'h0
`define ANS_STOP_ERR 2'h1
`define ANS_REJECT 2'h2

// mode-select encoding: deep stop when set
`define DEEP_SEL_VALUE 1'h1
// periodic wake rate value that disables it
`define RATE_OFF 3'h0
// reset value of the state register
`define STATE_RESET 4'h1
// cycles the illegal-opcode reset pulse stands
`define ILLOP_CYCLES 4'h4

`endif

/* File: design/sync2.v */
// Purpose: two-flop synchroniser for asynchronous level inputs
// Assumes: single clock SYS domain, async active-high reset
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // data
    input wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // two stages in series
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule
`default_nettype wire

/* File: design/bkgnd_cmd_filter.v */
// Purpose: decides the answer to a background command by power state
// Assumes: command strobe and class come from logic on the same clock
// Notes: registered answer, one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
`include "stop_ctrl_consts.vh"
module bkgnd_cmd_filter (
    // clock and reset
    input wire clk,
    input wire rst,
    // state
    input wire in_stop,
    input wire in_bkgnd,
    input wire debug_entry_enable,
    // command
    input wire cmd_valid,
    input wire [1:0] cmd_class,
    // answer
    output reg ans_valid_q,
    output reg [1:0] ans_code_q,
    output reg mem_access_q,
    output reg wake_req_q
);
    reg [1:0] code_d;
    reg access_d;
    reg wake_d;

    // classify a command against the current state
    always @* begin
        code_d = `ANS_OK;
        access_d = 1'b0;
        wake_d = 1'b0;
        if (in_bkgnd) begin
            access_d = (cmd_class != `CMD_BACKGROUND);
        end else if (in_stop) begin
            case (cmd_class)
                `CMD_MEM_STATUS: code_d = `ANS_STOP_ERR;
                `CMD_BACKGROUND: begin
                    wake_d = debug_entry_enable;
                    code_d = debug_entry_enable ? `ANS_OK : `ANS_REJECT;
                end
                default: code_d = `ANS_REJECT;
            endcase
        end else begin
            case (cmd_class)
                `CMD_ACTIVE_ONLY: code_d = `ANS_REJECT;
                `CMD_BACKGROUND: begin
                    wake_d = debug_entry_enable;
                    code_d = debug_entry_enable ? `ANS_OK : `ANS_REJECT;
                end
                default: access_d = 1'b1;
            endcase
        end
    end

    // register the answer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ans_valid_q <= 1'b0;
            ans_code_q <= `ANS_OK;
            mem_access_q <= 1'b0;
            wake_req_q <= 1'b0;
        end else begin
            ans_valid_q <= cmd_valid;
            ans_code_q <= cmd_valid ? code_d : `ANS_OK;
            mem_access_q <= cmd_valid & access_d;
            wake_req_q <= cmd_valid & wake_d;
        end
    end
endmodule
`default_nettype wire

/* File: tb/stop_ctrl_props.sv */
// Purpose: concurrent checks on stop entry, power state and command answers
// Assumes: bound to stop_mode_power_control, one clock domain
// Notes: stop entry is judged from run with no command pending
`timescale 1ns/1ps
`default_nettype none
module stop_ctrl_props (
    // clock, reset and requests
    input wire logic SYS_CLK, RST, STOP_EXEC, STOP_INSTRUCTION_ENABLE, DEEP_STOP_SELECT,
    input wire logic DEBUG_ENTRY_ENABLE, LOWVOLT_DETECT_ENABLE, LOWVOLT_STOP_ENABLE, CMD_VALID,
    input wire logic [1:0] CMD_CLASS,
    // answers and state
    input wire logic [1:0] CMD_ANS_CODE,
    input wire logic CMD_ANS_VALID, CMD_MEM_ACCESS, STOP_LIGHT, STOP_DEEP,
    input wire logic BACKGROUND_DEBUG_MODE, ILLEGAL_OPCODE_RESET, DEBUG_CLK_EN,
    // power controls
    input wire logic PERIPH_CLK_EN, REGULATOR_FULL, CPU_POWERED, FLASH_POWERED,
    input wire logic CONV_POWERED, CLOCK_GEN_POWERED, PIN_HOLD
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // helper terms for a stop request taken in run
    wire in_stop = STOP_LIGHT || STOP_DEEP;
    wire take = !in_stop && !BACKGROUND_DEBUG_MODE && STOP_EXEC && !CMD_VALID
        && !ILLEGAL_OPCODE_RESET;
    wire go = take && STOP_INSTRUCTION_ENABLE;
    wire lvs = LOWVOLT_DETECT_ENABLE && LOWVOLT_STOP_ENABLE;
    deep_entry_a: assert property (go && DEEP_STOP_SELECT && !DEBUG_ENTRY_ENABLE && !lvs
        |=> STOP_DEEP && !STOP_LIGHT) else $error("deep stop not entered");
    light_forced_a: assert property (go && (DEBUG_ENTRY_ENABLE || lvs)
        |=> STOP_LIGHT && !STOP_DEEP) else $error("light stop not forced");
    illegal_stop_a: assert property (take && !STOP_INSTRUCTION_ENABLE |=>
        (ILLEGAL_OPCODE_RESET && !in_stop)[*4] ##1 !ILLEGAL_OPCODE_RESET)
        else $error("illegal stop pulse wrong");
    periph_gate_a: assert property (in_stop |-> !PERIPH_CLK_EN)
        else $error("peripheral clock on in stop");
    debug_keep_a: assert property (go && DEBUG_ENTRY_ENABLE |=>
        DEBUG_CLK_EN && REGULATOR_FULL) else $error("debug stop lost clock");
    deep_off_a: assert property (STOP_DEEP |-> PIN_HOLD && !(CPU_POWERED ||
        FLASH_POWERED || CONV_POWERED || CLOCK_GEN_POWERED)) else $error("deep stop powered");
    stop_cmd_a: assert property (in_stop && CMD_VALID && CMD_CLASS == 2'h1 |=>
        CMD_ANS_VALID && CMD_ANS_CODE == 2'h1 && !CMD_MEM_ACCESS) else $error("status cmd ran");
    bkgnd_all_a: assert property (BACKGROUND_DEBUG_MODE && CMD_VALID |=>
        CMD_ANS_VALID && CMD_ANS_CODE == 2'h0) else $error("background cmd refused");
    // main scenarios reached
    deep_c: cover property (go ##1 STOP_DEEP);
    bkgnd_c: cover property ($rose(BACKGROUND_DEBUG_MODE));
    illegal_c: cover property ($rose(ILLEGAL_OPCODE_RESET));
endmodule
bind stop_mode_power_control stop_ctrl_props u_props (.*);
`default_nettype wire

/* File: tb/dbg_wake_model.sv */
// Purpose: debug host and wake source model facing the stop controller
// Assumes: tasks are entered 1 ns after a rising edge
// Notes: a released command class shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module dbg_wake_model (
    // clock
    input wire logic SYS_CLK,
    // debug host lines
    output logic CMD_VALID,
    output logic [1:0] CMD_CLASS,
    output logic DEBUG_GO,
    // wake sources
    output logic WAKE_PIN,
    output logic PERIODIC_WAKE_EVENT
);
    // idle lines at time zero
    initial begin
        {CMD_VALID, CMD_CLASS, DEBUG_GO, WAKE_PIN, PERIODIC_WAKE_EVENT} = 6'h0;
    end
    // one command strobe, held over one sampling edge
    task automatic cmd(input logic [1:0] c);
        CMD_CLASS = c;
        CMD_VALID = 1'b1;
        @(posedge SYS_CLK);
        #1;
        CMD_VALID = 1'b0;
        CMD_CLASS = ~c;
    endtask
    // leave background mode
    task automatic go();
        DEBUG_GO = 1'b1;
        @(posedge SYS_CLK);
        #1;
        DEBUG_GO = 1'b0;
    endtask
    // raise a wake level, pin or periodic source
    task automatic wake(input logic evt);
        if (evt) PERIODIC_WAKE_EVENT = 1'b1;
        else WAKE_PIN = 1'b1;
    endtask
    // drop both wake levels
    task automatic calm();
        {WAKE_PIN, PERIODIC_WAKE_EVENT} = 2'h0;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the stop-mode power controller
// Assumes: inputs move 1 ns after the rising edge
// Notes: expected states come from a small model of the stop behaviour
`timescale 1ns/1ps
`default_nettype none
module tb;
    // bench-driven inputs
    logic SYS_CLK, RST, STOP_EXEC, STOP_INSTRUCTION_ENABLE, DEEP_STOP_SELECT, LOWVOLT_BELOW;
    logic DEBUG_ENTRY_ENABLE, LOWVOLT_DETECT_ENABLE, LOWVOLT_STOP_ENABLE, LOWVOLT_RESET_SELECT;
    logic OSCILLATOR_STOP_ENABLE, CONV_ASYNC_CLK_ENABLE;
    logic [2:0] PERIODIC_WAKE_RATE_SELECT;
    // partner lines and design outputs
    wire CMD_VALID, DEBUG_GO, WAKE_PIN, PERIODIC_WAKE_EVENT, CMD_ANS_VALID, CMD_MEM_ACCESS;
    wire [1:0] CMD_CLASS, CMD_ANS_CODE;
    wire STOP_LIGHT, STOP_DEEP, BACKGROUND_DEBUG_MODE, ILLEGAL_OPCODE_RESET, LOWVOLT_INTERRUPT;
    wire LOWVOLT_RESET, DEBUG_CLK_EN, PERIPH_CLK_EN, REGULATOR_FULL, CPU_ON, CPU_POWERED;
    wire FLASH_POWERED, PORT_REGS_POWERED, SERIAL_POWERED, TIMER_POWERED, PIN_HOLD, CONV_RUN;
    wire CONV_POWERED, CLOCK_GEN_RUN, CLOCK_GEN_POWERED, PERIODIC_WAKE_RUN;
    wire [14:0] ctl = {DEBUG_CLK_EN, PERIPH_CLK_EN, REGULATOR_FULL, CPU_ON, CPU_POWERED,
        FLASH_POWERED, PORT_REGS_POWERED, SERIAL_POWERED, TIMER_POWERED, PIN_HOLD, CONV_RUN,
        CONV_POWERED, CLOCK_GEN_RUN, CLOCK_GEN_POWERED, PERIODIC_WAKE_RUN};
    wire stp = STOP_LIGHT | STOP_DEEP;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int i, m, n, s;
    logic [31:0] seed = 32'hE5A4989E;
    logic [31:0] r;
    logic [1:0] q[$];
    dbg_wake_model host (.*);
    stop_mode_power_control DUT (.*);
    // 50 MHz clock
    initial begin
        SYS_CLK = 1'b0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    // cut a hang short
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge SYS_CLK);
        #1;
    endtask
    task automatic chk(input logic [14:0] got, input logic [14:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected controls: 0 run, 1 light stop, 2 deep stop
    function automatic logic [14:0] model(input int md);
        logic d;
        logic p;
        d = DEBUG_ENTRY_ENABLE;
        p = PERIODIC_WAKE_RATE_SELECT != 3'h0;
        if (md == 0) return {9'h1FF, 1'b0, 4'hF, p};
        if (md == 2) return {9'h000, 1'b1, 4'h0, p};
        return {d, 1'b0, d | (LOWVOLT_DETECT_ENABLE & LOWVOLT_STOP_ENABLE), 1'b0, 5'h1F, 1'b1,
            CONV_ASYNC_CLK_ENABLE & LOWVOLT_DETECT_ENABLE, 1'b1, OSCILLATOR_STOP_ENABLE | d,
            1'b1, p};
    endfunction
    // expected answer code: state 0 run, 1 stop, 3 background
    function automatic logic [1:0] ans(input int st, input logic [1:0] c);
        if (st == 3) return 2'h0;
        if (st == 1) return (c == 2'h1) ? 2'h1 : (c == 2'h2 && DEBUG_ENTRY_ENABLE) ? 2'h0 : 2'h2;
        return (c == 2'h3 || (c == 2'h2 && !DEBUG_ENTRY_ENABLE)) ? 2'h2 : 2'h0;
    endfunction
    task automatic cmdchk(input int st, input logic [1:0] c);
        q.push_back(ans(st, c));
        host.cmd(c);
        // the answer stands for the single cycle right after the strobe edge
        chk(15'(CMD_ANS_VALID), 15'h1);
        chk(15'(CMD_ANS_CODE), 15'(q.pop_front()));
        if (c == 2'h1) chk(15'(CMD_MEM_ACCESS), 15'(st != 1));
    endtask
    task automatic to_run();
        for (n = 0; n < 12 && stp !== 1'b0; n++) tick(1);
        host.calm();
        tick(3);
        chk(15'(stp), 15'h0);
        chk(ctl, model(0));
    endtask
    // main sequence
    initial begin
        {RST, STOP_EXEC, STOP_INSTRUCTION_ENABLE, DEEP_STOP_SELECT, LOWVOLT_BELOW} = 5'h14;
        {DEBUG_ENTRY_ENABLE, LOWVOLT_DETECT_ENABLE, LOWVOLT_STOP_ENABLE} = 3'h0;
        {LOWVOLT_RESET_SELECT, OSCILLATOR_STOP_ENABLE, CONV_ASYNC_CLK_ENABLE} = 3'h0;
        PERIODIC_WAKE_RATE_SELECT = 3'h0;
        tick(4);
        RST = 1'b0;
        for (i = 0; i < 24; i++) begin
            r = xs();
            {LOWVOLT_RESET_SELECT, CONV_ASYNC_CLK_ENABLE, OSCILLATOR_STOP_ENABLE} = r[2:0];
            {DEEP_STOP_SELECT, LOWVOLT_STOP_ENABLE, LOWVOLT_DETECT_ENABLE} = r[5:3];
            DEBUG_ENTRY_ENABLE = r[6] & r[10];
            PERIODIC_WAKE_RATE_SELECT = r[9:7];
            if (LOWVOLT_DETECT_ENABLE & LOWVOLT_STOP_ENABLE) OSCILLATOR_STOP_ENABLE = r[6] & r[10];
            m = (DEEP_STOP_SELECT && model(1) == model(2)) ? 2 : 1;
            m = (DEEP_STOP_SELECT && !DEBUG_ENTRY_ENABLE && !(r[3] && r[4])) ? 2 : 1;
            tick(2);
            STOP_EXEC = 1'b1;
            tick(1);
            STOP_EXEC = 1'b0;
            tick(1);
            chk(15'({STOP_DEEP, STOP_LIGHT}), 15'(m));
            chk(ctl, model(m));
            cmdchk(1, 2'h1);
            cmdchk(1, r[11] ? 2'h0 : 2'h3);
            if (PERIODIC_WAKE_RATE_SELECT == 3'h0) begin
                host.wake(1'b1);
                tick(8);
                chk(15'(stp), 15'h1);
            end
            if (DEBUG_ENTRY_ENABLE) begin
                cmdchk(1, 2'h2);
                tick(1);
                chk(15'({BACKGROUND_DEBUG_MODE, CPU_ON, STOP_LIGHT}), 15'h4);
                cmdchk(3, 2'h3);
                cmdchk(3, 2'h1);
                host.go();
                tick(2);
            end else begin
                if (r[12]) cmdchk(1, 2'h2);
                host.wake(r[13] && PERIODIC_WAKE_RATE_SELECT != 3'h0);
            end
            to_run();
        end
        $display("done: stop entry and wake");
        for (i = 0; i < 8; i++) begin
            DEBUG_ENTRY_ENABLE = i[2];
            tick(1);
            cmdchk(0, i[1:0]);
            tick(1);
            chk(15'(BACKGROUND_DEBUG_MODE), 15'(i == 6));
            if (i == 6) host.go();
            tick(2);
        end
        $display("done: run commands");
        STOP_INSTRUCTION_ENABLE = 1'b0;
        STOP_EXEC = 1'b1;
        tick(1);
        STOP_EXEC = 1'b0;
        {n, s} = 64'h0;
        // the pulse already stands one ns after the edge that took the stop
        repeat (8) begin
            n += (ILLEGAL_OPCODE_RESET === 1'b1);
            s += (stp !== 1'b0);
            tick(1);
        end
        chk(15'(n * 16 + s), 15'h40);
        STOP_INSTRUCTION_ENABLE = 1'b1;
        $display("done: illegal stop");
        for (i = 0; i < 4; i++) begin
            {LOWVOLT_DETECT_ENABLE, LOWVOLT_RESET_SELECT} = i[1:0];
            tick(2);
            LOWVOLT_BELOW = 1'b1;
            {n, s} = 64'h0;
            repeat (8) begin
                tick(1);
                n += (LOWVOLT_INTERRUPT === 1'b1);
                s += (LOWVOLT_RESET === 1'b1);
            end
            chk(15'(n * 16 + s), 15'((i == 2) * 16 + (i == 3)));
            LOWVOLT_BELOW = 1'b0;
            tick(4);
        end
        $display("done: low voltage events");
        end_sim();
    end
endmodule
`default_nettype wire
